// [core/acu_axis_cmd.sv]
// Local design decisions: the strobed register port and the register offsets.
`include "acu_consts.svh"
`default_nettype none
// Port: addr 0 command, 1 I/O buffer, 2 status, 3 pin view
module acu_axis_cmd #(
  parameter logic [15:0] ID_CODE = 16'h5A_A5,
  parameter int DATA_W = 32
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  output logic [DATA_W-1:0] rd_data,
  input wire logic [7:0] gp_pin_in,
  output logic [7:0] gp_pin_out,
  output logic [7:0] gp_pin_oe,
  output logic deviation_clear_pin,
  input wire logic count1_step,
  input wire logic count2_step,
  input wire logic latch3_trigger,
  input wire logic latch4_trigger,
  input wire logic op_complete,
  input wire logic stop_event,
  input wire logic off_target_event,
  output logic axis_running,
  output logic override_two_start,
  output logic queue_full_flag,
  output logic stop_irq_flag,
  output logic off_target_stop_flag
);
  localparam int NQ = 11;

  logic [7:0] gp_in_meta;
  logic [7:0] gp_in_sync;
  logic [3:0] trig_meta;
  logic [3:0] trig_sync;
  logic [3:0] trig_prev;
  logic [DATA_W-1:0] io_buffer;
  logic [7:0] gp_dir;
  logic [15:0] shared_port_direction_reg;
  logic [15:0] shared_port_data_reg;
  logic [DATA_W-1:0] first_counter;
  logic [DATA_W-1:0] second_counter;
  logic [DATA_W-1:0] first_latch_reg;
  logic [DATA_W-1:0] second_latch_reg;
  logic [DATA_W-1:0] third_latch_reg;
  logic [DATA_W-1:0] fourth_latch_reg;
  logic [DATA_W-1:0] environment_setting_two;
  logic latch3_watch;
  logic latch4_watch;
  logic id_exposed;
  logic soft_rst;
  logic [3:0] hold_count;
  acu_pkg::acu_run_type run_state;
  acu_pkg::acu_run_type next_run_state;
  logic [DATA_W-1:0] pre_q [NQ];
  logic [DATA_W-1:0] reg_q [NQ];
  logic [DATA_W-1:0] next_rd_data;

  wire logic cmd_wr = wr_strobe && (addr == `ACU_ADDR_CMD) && !soft_rst;
  wire logic [7:0] cmd = wr_data[7:0];
  wire logic is_start = cmd_wr && (cmd >= `ACU_CMD_START_LO)
    && (cmd <= `ACU_CMD_START_HI);
  wire logic is_stop = cmd_wr && ((cmd == `ACU_CMD_STOP)
    || (cmd == `ACU_CMD_SDSTOP));
  wire logic pre_wr_cmd = cmd_wr && (cmd[7:4] == `ACU_CMD_PRE_WR >> 4)
    && (cmd[3:0] <= `ACU_QIDX_LAST);
  wire logic reg_wr_cmd = cmd_wr && (cmd[7:4] == `ACU_CMD_REG_WR >> 4)
    && (cmd[3:0] <= `ACU_QIDX_LAST);
  wire logic pre_accept = pre_wr_cmd && !queue_full_flag; // R21
  wire logic manual_clear = environment_setting_two[`ACU_ENV2_MANUAL_FLAG_CLEAR_SELECT];
  wire logic advance = op_complete
    && (run_state == acu_pkg::ACU_RUN_QUEUED); // R20

  assign axis_running = (run_state != acu_pkg::ACU_IDLE);
  assign queue_full_flag = (run_state == acu_pkg::ACU_RUN_QUEUED);

  // Inputs from pins pass two flip-flops first
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      gp_in_meta <= 8'h00;
      gp_in_sync <= 8'h00;
      trig_meta <= 4'h0;
      trig_sync <= 4'h0;
    end else begin
      gp_in_meta <= gp_pin_in;
      gp_in_sync <= gp_in_meta;
      trig_meta <= {latch4_trigger, latch3_trigger,
        count2_step, count1_step};
      trig_sync <= trig_meta;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      trig_prev <= 4'h0;
    end else begin
      trig_prev <= trig_sync;
    end
  end

  // Soft reset holds the core cleared
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      soft_rst <= 1'b0;
      hold_count <= 4'h0;
    end else if (cmd_wr && cmd == `ACU_CMD_SOFT_RESET_CMD) begin
      soft_rst <= 1'b1; // R4
      hold_count <= `ACU_RESET_HOLD;
    end else if (hold_count != 4'h0) begin
      hold_count <= hold_count - 4'h1;
      soft_rst <= (hold_count != 4'h1);
    end else begin
      soft_rst <= 1'b0;
    end
  end

  genvar q;
  generate
    for (q = 0; q < NQ; q++) begin : g_queue
      acu_queue #(.WIDTH(DATA_W)) u_queue (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .soft_rst(soft_rst),
        .pre_wr(pre_accept && cmd[3:0] == q),
        .reg_wr(reg_wr_cmd && cmd[3:0] == q),
        .pass_through(run_state == acu_pkg::ACU_IDLE), // R19
        .advance(advance),
        .wr_data(io_buffer),
        .pre_value(pre_q[q]),
        .reg_value(reg_q[q])
      );
    end
  endgenerate

  // Run / queue state
  always_comb begin
    next_run_state = run_state;
    case (run_state)
      acu_pkg::ACU_IDLE: begin
        if (is_start) begin
          next_run_state = acu_pkg::ACU_RUN; // R20
        end
      end
      acu_pkg::ACU_RUN: begin
        if (is_stop || op_complete) begin
          next_run_state = acu_pkg::ACU_IDLE;
        end else if (is_start) begin
          next_run_state = acu_pkg::ACU_RUN_QUEUED; // R20
        end
      end
      acu_pkg::ACU_RUN_QUEUED: begin
        if (is_stop) begin
          next_run_state = acu_pkg::ACU_IDLE;
        end else if (op_complete) begin
          next_run_state = acu_pkg::ACU_RUN; // R20
        end else if (cmd_wr && cmd == `ACU_CMD_QCAN) begin
          next_run_state = acu_pkg::ACU_RUN; // R7
        end
      end
      default: begin
        next_run_state = acu_pkg::ACU_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      run_state <= acu_pkg::ACU_IDLE;
    end else if (soft_rst) begin
      run_state <= acu_pkg::ACU_IDLE;
    end else begin
      run_state <= next_run_state;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      override_two_start <= 1'b0;
    end else begin
      override_two_start <= cmd_wr && cmd == `ACU_CMD_OVR2; // R8
    end
  end

  // General-purpose pins, one per bit; input pins ignore commands
  genvar p;
  generate
    for (p = 0; p < 8; p++) begin : g_pin
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          gp_pin_out[p] <= 1'b0;
        end else if (soft_rst) begin
          gp_pin_out[p] <= 1'b0;
        end else if (cmd_wr && gp_dir[p] && cmd[2:0] == p) begin // R3
          if (cmd[7:3] == `ACU_CMD_PLOW) begin
            gp_pin_out[p] <= 1'b0; // R1
          end else if (cmd[7:3] == `ACU_CMD_PHIGH) begin
            gp_pin_out[p] <= 1'b1; // R2
          end
        end
      end
    end
  endgenerate
  assign gp_pin_oe = gp_dir;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      deviation_clear_pin <= 1'b0;
    end else if (soft_rst) begin
      deviation_clear_pin <= 1'b0;
    end else if (cmd_wr && cmd == `ACU_CMD_DEVON) begin
      deviation_clear_pin <= 1'b1; // R6
    end else if (cmd_wr && cmd == `ACU_CMD_DEVOFF) begin
      deviation_clear_pin <= 1'b0; // R6
    end
  end

  // Counters: clear wins over counting
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      first_counter <= '0;
      second_counter <= '0;
    end else if (soft_rst) begin
      first_counter <= '0;
      second_counter <= '0;
    end else begin
      if (cmd_wr && cmd == `ACU_CMD_C1CLR) begin
        first_counter <= '0; // R5
      end else if (cmd_wr
          && cmd == `ACU_CMD_REG_WR + `ACU_IDX_CUN1 - 8'h10) begin
        first_counter <= io_buffer;
      end else if (trig_sync[0] && !trig_prev[0]) begin
        first_counter <= first_counter + 1'b1; // R17
      end
      if (cmd_wr && cmd == `ACU_CMD_C2CLR) begin
        second_counter <= '0; // R5
      end else if (cmd_wr
          && cmd == `ACU_CMD_REG_WR + `ACU_IDX_CUN2 - 8'h10) begin
        second_counter <= io_buffer;
      end else if (trig_sync[1] && !trig_prev[1]) begin
        second_counter <= second_counter + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      first_latch_reg <= '0;
      second_latch_reg <= '0;
    end else if (soft_rst) begin
      first_latch_reg <= '0;
      second_latch_reg <= '0;
    end else if (cmd_wr && cmd == `ACU_CMD_SNAP) begin
      first_latch_reg <= first_counter; // R9
      second_latch_reg <= second_counter; // R9
    end
  end

  // Trigger-driven latches
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      latch3_watch <= 1'b0;
      latch4_watch <= 1'b0;
      third_latch_reg <= '0;
      fourth_latch_reg <= '0;
    end else if (soft_rst) begin
      latch3_watch <= 1'b0;
      latch4_watch <= 1'b0;
      third_latch_reg <= '0;
      fourth_latch_reg <= '0;
    end else begin
      if (cmd_wr && cmd == `ACU_CMD_L3ON) begin
        latch3_watch <= 1'b1; // R10
      end else if (cmd_wr && cmd == `ACU_CMD_L3OFF) begin
        latch3_watch <= 1'b0; // R10
      end
      if (cmd_wr && cmd == `ACU_CMD_L4ON) begin
        latch4_watch <= 1'b1; // R10
      end else if (cmd_wr && cmd == `ACU_CMD_L4OFF) begin
        latch4_watch <= 1'b0; // R10
      end
      if (latch3_watch && trig_sync[2] && !trig_prev[2]) begin
        third_latch_reg <= first_counter;
      end
      if (latch4_watch && trig_sync[3] && !trig_prev[3]) begin
        fourth_latch_reg <= second_counter;
      end
    end
  end

  // Status flags: set wins over clear
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stop_irq_flag <= 1'b0;
      off_target_stop_flag <= 1'b0;
    end else if (soft_rst) begin
      stop_irq_flag <= 1'b0;
      off_target_stop_flag <= 1'b0;
    end else begin
      if (stop_event) begin
        stop_irq_flag <= 1'b1;
      end else if ((manual_clear && cmd_wr && cmd == `ACU_CMD_STOPCLR)
          || (!manual_clear && rd_strobe && addr == `ACU_ADDR_STAT)) begin
        stop_irq_flag <= 1'b0; // R11 R23
      end
      if (off_target_event) begin
        off_target_stop_flag <= 1'b1;
      end else if ((manual_clear && cmd_wr && cmd == `ACU_CMD_OFFCLR)
          || (!manual_clear && rd_strobe && addr == `ACU_ADDR_STAT)) begin
        off_target_stop_flag <= 1'b0; // R11
      end
    end
  end

  // Identity clears on the next command
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      id_exposed <= 1'b0;
    end else if (soft_rst) begin
      id_exposed <= 1'b0;
    end else if (cmd_wr) begin
      id_exposed <= (cmd == `ACU_CMD_ID); // R12
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      environment_setting_two <= '0;
      gp_dir <= 8'h00;
      shared_port_direction_reg <= 16'h0000;
      shared_port_data_reg <= 16'h0000;
    end else if (soft_rst) begin
      environment_setting_two <= '0;
      gp_dir <= 8'h00;
      shared_port_direction_reg <= 16'h0000;
      shared_port_data_reg <= 16'h0000;
    end else if (cmd_wr) begin
      if (cmd == `ACU_CMD_REG_WR + `ACU_IDX_ENV2 - 8'h10) begin
        environment_setting_two <= io_buffer;
        gp_dir <= io_buffer[15:8];
      end else if (cmd == `ACU_CMD_REG_WR + `ACU_IDX_PDIR - 8'h10) begin
        shared_port_direction_reg <= io_buffer[15:0]; // R15
      end else if (cmd == `ACU_CMD_REG_WR + `ACU_IDX_PDATA - 8'h10) begin
        shared_port_data_reg <= io_buffer[15:0]; // R15 R18
      end
    end
  end

  // Register read into I/O buffer, unused bits zero or sign copies
  always_comb begin
    next_rd_data = io_buffer;
    if (cmd[7:4] == `ACU_CMD_REG_RD >> 4 && cmd[3:0] <= `ACU_QIDX_LAST) begin
      next_rd_data = reg_q[cmd[3:0]]; // R14
    end else if (cmd[7:4] == `ACU_CMD_PRE_RD >> 4
        && cmd[3:0] <= `ACU_QIDX_LAST) begin
      next_rd_data = pre_q[cmd[3:0]]; // R14
    end else if (cmd == `ACU_CMD_REG_RD + `ACU_IDX_ENV2 - 8'h10) begin
      next_rd_data = environment_setting_two;
    end else if (cmd == `ACU_CMD_REG_RD + `ACU_IDX_CUN1 - 8'h10) begin
      next_rd_data = first_counter;
    end else if (cmd == `ACU_CMD_REG_RD + `ACU_IDX_CUN2 - 8'h10) begin
      next_rd_data = second_counter;
    end else if (cmd == `ACU_CMD_REG_RD + `ACU_IDX_LTC1 - 8'h10) begin
      next_rd_data = first_latch_reg;
    end else if (cmd == `ACU_CMD_REG_RD + `ACU_IDX_LTC2 - 8'h10) begin
      next_rd_data = second_latch_reg;
    end else if (cmd == `ACU_CMD_REG_RD + `ACU_IDX_LTC3 - 8'h10) begin
      next_rd_data = third_latch_reg;
    end else if (cmd == `ACU_CMD_REG_RD + `ACU_IDX_LTC4 - 8'h10) begin
      next_rd_data = fourth_latch_reg;
    end else if (cmd == `ACU_CMD_REG_RD + `ACU_IDX_PDIR - 8'h10) begin
      next_rd_data = {16'h0000, shared_port_direction_reg}; // R15 R18
    end else if (cmd == `ACU_CMD_REG_RD + `ACU_IDX_PDATA - 8'h10) begin
      next_rd_data = {16'h0000, shared_port_data_reg}; // R15
    end
    if (cmd == `ACU_CMD_REG_RD + `ACU_IDX_SPEEDMUL) begin
      next_rd_data = {(id_exposed ? ID_CODE : 16'h0000), 4'h0, // R12 R18
        reg_q[`ACU_IDX_SPEEDMUL][`ACU_MG_BITS-1:0]};
    end else if (cmd == `ACU_CMD_REG_RD + 8'h06) begin
      next_rd_data = {{(DATA_W-`ACU_RDP_BITS){reg_q[6][`ACU_RDP_BITS-1]}},
        reg_q[6][`ACU_RDP_BITS-1:0]}; // R17 R18
    end
  end

  // I/O buffer; unknown codes and NOP leave it alone
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      io_buffer <= '0;
    end else if (soft_rst) begin
      io_buffer <= '0;
    end else if (wr_strobe && addr == `ACU_ADDR_BUF) begin
      io_buffer <= wr_data;
    end else if (cmd_wr) begin
      io_buffer <= next_rd_data; // R13 R24
    end
  end

  // Read data one cycle after the strobe
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= '0;
    end else if (rd_strobe) begin
      if (addr == `ACU_ADDR_BUF) begin
        rd_data <= io_buffer;
      end else if (addr == `ACU_ADDR_STAT) begin
        rd_data <= {17'h0_0000, queue_full_flag, off_target_stop_flag,
          10'h000, stop_irq_flag, axis_running, soft_rst};
      end else if (addr == `ACU_ADDR_EVT) begin
        rd_data <= {16'h0000, gp_in_sync, gp_pin_out};
      end else begin
        rd_data <= '0;
      end
    end else begin
      rd_data <= '0;
    end
  end
endmodule
`default_nettype wire

// [core/acu_consts.svh]
// Behaviour
// (R1) Codes 10h-17h drive output pin low
// (R2) Codes 18h-1Fh drive output pin high
// (R3) Pin commands ignored on input pins
// (R4) 04h resets device; host waits 12 clocks
// (R5) 20h/21h clear first/second counter
// (R6) 24h asserts, 25h releases deviation clear
// (R7) 26h returns queue to unfixed
// (R8) 28h starts override-two positioning
// (R9) 29h snapshots both counters together
// (R10) 3Ch/3Dh watch on, 3Eh/3Fh off
// (R11) Manual mode: 2Dh/2Eh clear stop flags
// (R12) 03h exposes identity once via D5h
// (R13) 00h accepted, changes nothing; code still clears id_exposed
// (R14) Register reads/writes move via I/O buffer
// (R15) Two shared 16-bit port registers
// (R16) All registers zero after reset
// (R17) Signed values in two's complement
// (R18) Unused bits ignore writes, read zero/sign
// (R19) Queue writes pass through when stopped
// (R20) Start fixes data; auto restart on completion
// (R21) Pre-register writes refused while queue full
// (R22) Host overrides via working registers
// (R23) Stop flag clears within 3 clocks
// (R24) Undefined codes ignored; code still clears id_exposed on them
`ifndef ACU_CONSTS_SVH
`define ACU_CONSTS_SVH
`define ACU_CMD_NOP 8'h00
`define ACU_CMD_ID 8'h03
`define ACU_CMD_SOFT_RESET_CMD 8'h04
`define ACU_CMD_PLOW 5'b0_0010
`define ACU_CMD_PHIGH 5'b0_0011
`define ACU_CMD_C1CLR 8'h20
`define ACU_CMD_C2CLR 8'h21
`define ACU_CMD_DEVON 8'h24
`define ACU_CMD_DEVOFF 8'h25
`define ACU_CMD_QCAN 8'h26
`define ACU_CMD_OVR2 8'h28
`define ACU_CMD_SNAP 8'h29
`define ACU_CMD_STOPCLR 8'h2D
`define ACU_CMD_OFFCLR 8'h2E
`define ACU_CMD_L3ON 8'h3C
`define ACU_CMD_L4ON 8'h3D
`define ACU_CMD_L3OFF 8'h3E
`define ACU_CMD_L4OFF 8'h3F
`define ACU_CMD_START_LO 8'h50
`define ACU_CMD_START_HI 8'h53
`define ACU_CMD_STOP 8'h49
`define ACU_CMD_SDSTOP 8'h4A
`define ACU_CMD_PRE_WR 8'h80
`define ACU_CMD_REG_WR 8'h90
`define ACU_CMD_PRE_RD 8'hC0
`define ACU_CMD_REG_RD 8'hD0
`define ACU_QIDX_LAST 4'hA
`define ACU_IDX_SPEEDMUL 4'h5
`define ACU_IDX_ENV2 8'h1D
`define ACU_IDX_CUN1 8'h23
`define ACU_IDX_CUN2 8'h24
`define ACU_IDX_LTC1 8'h2D
`define ACU_IDX_LTC2 8'h2E
`define ACU_IDX_LTC3 8'h2F
`define ACU_IDX_LTC4 8'h30
`define ACU_IDX_STATUS 8'h31
`define ACU_IDX_PDIR 8'h3A
`define ACU_IDX_PDATA 8'h3B
`define ACU_ENV2_MANUAL_FLAG_CLEAR_SELECT 5
`define ACU_MG_BITS 12
`define ACU_RDP_BITS 24
`define ACU_RESET_HOLD 4'hC
`define ACU_ADDR_CMD 2'h0
`define ACU_ADDR_BUF 2'h1
`define ACU_ADDR_STAT 2'h2
`define ACU_ADDR_EVT 2'h3
`endif

// [core/acu_pkg.sv]
`default_nettype none
package acu_pkg;
  typedef enum logic [2:0] {
    ACU_IDLE = 3'b001,
    ACU_RUN = 3'b010,
    ACU_RUN_QUEUED = 3'b100
  } acu_run_type;
endpackage
`default_nettype wire

// [core/acu_queue.sv]
`include "acu_consts.svh"
`default_nettype none
// Two-stage pre-register / register pair for one queued parameter
module acu_queue #(
  parameter int WIDTH = 32
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic soft_rst,
  input wire logic pre_wr,
  input wire logic reg_wr,
  input wire logic pass_through,
  input wire logic advance,
  input wire logic [WIDTH-1:0] wr_data,
  output logic [WIDTH-1:0] pre_value,
  output logic [WIDTH-1:0] reg_value
);
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pre_value <= '0; // R16
    end else if (soft_rst) begin
      pre_value <= '0; // R16
    end else if (pre_wr) begin
      pre_value <= wr_data;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_value <= '0;
    end else if (soft_rst) begin
      reg_value <= '0;
    end else if (reg_wr || (pre_wr && pass_through)) begin
      reg_value <= wr_data; // R19
    end else if (advance) begin
      reg_value <= pre_value; // R20
    end
  end
endmodule
`default_nettype wire

// [verif/acu_props.sv]
`default_nettype none
module acu_props #(
  parameter int DATA_W = 32
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic [7:0] gp_pin_out,
  input wire logic [7:0] gp_pin_oe,
  input wire logic deviation_clear_pin,
  input wire logic override_two_start,
  input wire logic queue_full_flag,
  input wire logic stop_irq_flag
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  logic [3:0] hold;
  logic [2:0] pin;
  logic buf5, manual, go;
  logic [7:0] cmd;
  assign cmd = wr_data[7:0];
  assign go = wr_strobe && addr == 2'h0 && hold == 4'h0;
  // Soft reset blanks commands
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      hold <= 4'h0;
    end else if (go && cmd == 8'h04) begin
      hold <= 4'hD;
    end else if (hold != 4'h0) begin
      hold <= hold - 4'h1;
    end
  end
  // Manual clear select
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pin <= 3'h0;
      buf5 <= 1'b0;
      manual <= 1'b0;
    end else begin
      pin <= cmd[2:0];
      if (wr_strobe && addr == 2'h1) begin
        buf5 <= wr_data[5];
      end
      if (hold != 4'h0) begin
        manual <= 1'b0;
      end else if (go && cmd == 8'h9D) begin
        manual <= buf5;
      end
    end
  end
  pin_low_a: assert property (
    go && cmd[7:3] == 5'h02 && gp_pin_oe[cmd[2:0]] |=> !gp_pin_out[pin])
    else $error("pin not low");
  pin_high_a: assert property (
    go && cmd[7:3] == 5'h03 && gp_pin_oe[cmd[2:0]] |=> gp_pin_out[pin])
    else $error("pin not high");
  pin_input_a: assert property (
    go && cmd[7:4] == 4'h1 && !gp_pin_oe[cmd[2:0]] |=> $stable(gp_pin_out))
    else $error("input pin moved");
  dev_set_a: assert property (
    go && cmd == 8'h24 |=> deviation_clear_pin) else $error("pin low");
  dev_drop_a: assert property (
    go && cmd == 8'h25 |=> !deviation_clear_pin) else $error("pin high");
  ovr_pulse_a: assert property (
    go && cmd == 8'h28 |=> override_two_start ##1 !override_two_start)
    else $error("no start pulse");
  rd_idle_a: assert property (
    !rd_strobe |=> rd_data == '0) else $error("read data not idle");
  stop_clr_a: assert property (
    go && cmd == 8'h2D && manual && stop_irq_flag |-> ##[1:3] !stop_irq_flag)
    else $error("stop flag held");
  qcan_a: assert property (
    go && cmd == 8'h26 |=> !queue_full_flag) else $error("queue still fixed");
  c_soft_reset_cmd: cover property (go && cmd == 8'h04);
  c_unfix: cover property ($fell(queue_full_flag));
  c_stopclr: cover property (manual && $fell(stop_irq_flag));
endmodule
`default_nettype wire

// [verif/acu_host_model.sv]
`default_nettype none
// Host side of the command port
module acu_host_model (
  input wire logic clk_sys,
  output logic [1:0] addr,
  output logic [31:0] wr_data,
  output logic wr_strobe,
  output logic rd_strobe,
  input wire logic [31:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr = 2'h0;
    wr_data = 32'h0;
    wr_strobe = 1'b0;
    rd_strobe = 1'b0;
  end
  task automatic put(input logic [1:0] a, input logic [31:0] v);
    addr <= a;
    wr_data <= v;
    wr_strobe <= 1'b1;
    @(posedge clk_sys);
    wr_strobe <= 1'b0;
    wr_data <= ~v;
    @(posedge clk_sys);
  endtask
  task automatic cmd(input logic [7:0] c);
    put(2'h0, {24'h0, c});
    if (c == 8'h04) begin
      repeat (12) @(posedge clk_sys);
    end
  endtask
  task automatic get(input logic [1:0] a, output logic [31:0] v);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge clk_sys);
    rd_strobe <= 1'b0;
    @(posedge clk_sys);
    v = rd_data;
  endtask
  task automatic reg_wr(input logic [7:0] c, input logic [31:0] v);
    put(2'h1, v);
    cmd(c);
  endtask
  task automatic reg_rd(input logic [7:0] c, output logic [31:0] v);
    cmd(c);
    get(2'h1, v);
  endtask
endmodule
`default_nettype wire

// [verif/testbench.sv]
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // Arbitrary identity value
  localparam logic [15:0] ID = 16'h3CC3;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] addr;
  logic [31:0] wr_data, rd_data, d, v1, v2, v3;
  logic wr_strobe, rd_strobe, dev, c1, c2, t3, t4, opc, stp, off;
  logic run, ovr, full, sflag, oflag;
  logic [7:0] gin, gout, goe, dir, ex;
  int bad_count = 0;
  int total_checks = 0;
  int i, n1, n2;
  always #2.5 clk_sys = ~clk_sys;
  acu_axis_cmd #(.ID_CODE(ID), .DATA_W(32)) i_acu_axis_cmd (
    .clk_sys(clk_sys), .reset_n(reset_n), .addr(addr), .wr_data(wr_data),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data),
    .gp_pin_in(gin), .gp_pin_out(gout), .gp_pin_oe(goe),
    .deviation_clear_pin(dev), .count1_step(c1), .count2_step(c2),
    .latch3_trigger(t3), .latch4_trigger(t4), .op_complete(opc),
    .stop_event(stp), .off_target_event(off), .axis_running(run),
    .override_two_start(ovr), .queue_full_flag(full),
    .stop_irq_flag(sflag), .off_target_stop_flag(oflag));
  acu_host_model host (
    .clk_sys(clk_sys), .addr(addr), .wr_data(wr_data),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [7:0] c, input logic [31:0] e);
    host.reg_rd(c, d);
    chk(d, e);
  endtask
  task automatic steps(input int a, input int b);
    for (int k = 0; k < 5; k++) begin
      c1 <= k < a;
      c2 <= k < b;
      repeat (2) @(posedge clk_sys);
      {c1, c2} <= 2'b00;
      repeat (2) @(posedge clk_sys);
    end
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic trig();
    {t3, t4} <= 2'b11;
    repeat (3) @(posedge clk_sys);
    {t3, t4} <= 2'b00;
    repeat (5) @(posedge clk_sys);
  endtask
  task automatic pulse(input logic [2:0] m);
    {opc, stp, off} <= m;
    @(posedge clk_sys);
    {opc, stp, off} <= 3'h0;
    @(posedge clk_sys);
  endtask
  task automatic note(input string s);
    $display("test %s done", s);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    complete_run();
  end
  initial begin
    {gin, c1, c2, t3, t4, opc, stp, off} = 15'h0000;
    void'($urandom(32'h065e_bad9));
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    for (i = 0; i < 11; i++) begin
      rchk(8'hD0 + 8'(i), 32'h0);
      rchk(8'hC0 + 8'(i), 32'h0);
    end
    chk(32'({gout, dev, run, full, sflag, oflag}), 32'h0);
    note("reset");
    dir = (8'($urandom) & 8'h7E) | 8'h01;
    host.reg_wr(8'h9D, {16'h0, dir, 8'h00});
    chk(32'(goe), 32'(dir));
    ex = 8'h00;
    for (i = 0; i < 8; i++) begin
      host.cmd(8'h18 + 8'(i));
      ex[i] = dir[i];
      chk(32'(gout), 32'(ex));
    end
    for (i = 0; i < 8; i++) begin
      host.cmd(8'h10 + 8'(i));
      ex[i] = 1'b0;
      chk(32'(gout), 32'(ex));
    end
    gin <= 8'($urandom);
    host.cmd(8'h18);
    host.get(2'h3, d);
    chk(d, {16'h0, gin, 8'h01});
    host.cmd(8'h24);
    chk(32'(dev), 32'h1);
    for (i = 0; i < 3; i++) begin
      host.cmd(i == 0 ? 8'h00 : (i == 1 ? 8'h0F : 8'h7F));
      chk(32'({dev, gout, run}), 32'h202);
    end
    host.cmd(8'h25);
    chk(32'(dev), 32'h0);
    note("pins");
    v1 = $urandom;
    host.reg_wr(8'h95, v1);
    host.cmd(8'h03);
    rchk(8'hD5, {ID, 4'h0, v1[11:0]});
    rchk(8'hD5, {20'h0, v1[11:0]});
    host.cmd(8'h03);
    host.cmd(8'h20);
    rchk(8'hD5, {20'h0, v1[11:0]});
    v2 = $urandom | 32'h0080_0000;
    host.reg_wr(8'h96, v2);
    rchk(8'hD6, {8'hFF, v2[23:0]});
    for (i = 0; i < 2; i++) begin
      v1 = $urandom;
      host.reg_wr(8'hBA + 8'(i), v1);
      rchk(8'hFA + 8'(i), {16'h0, v1[15:0]});
    end
    note("registers");
    n1 = 1 + $urandom % 5;
    n2 = 1 + $urandom % 5;
    steps(n1, n2);
    host.cmd(8'h29);
    steps(1, 1);
    rchk(8'hED, 32'(n1));
    rchk(8'hEE, 32'(n2));
    host.cmd(8'h3C);
    host.cmd(8'h3D);
    trig();
    rchk(8'hEF, 32'(n1 + 1));
    rchk(8'hF0, 32'(n2 + 1));
    host.cmd(8'h3E);
    host.cmd(8'h3F);
    steps(1, 1);
    trig();
    rchk(8'hEF, 32'(n1 + 1));
    rchk(8'hF0, 32'(n2 + 1));
    host.cmd(8'h20);
    rchk(8'hE3, 32'h0);
    rchk(8'hE4, 32'(n2 + 2));
    host.cmd(8'h21);
    rchk(8'hE4, 32'h0);
    note("counters");
    pulse(3'b011);
    host.get(2'h2, d);
    chk(32'({d[15:0], sflag, oflag}), 32'h0000_8010);
    host.reg_wr(8'h9D, {16'h0, dir, 8'h20});
    pulse(3'b011);
    host.get(2'h2, d);
    chk(32'({sflag, oflag}), 32'h3);
    host.cmd(8'h2D);
    for (i = 0; i < 3 && sflag !== 1'b0; i++) @(posedge clk_sys);
    chk(32'({sflag, oflag}), 32'h1);
    if (sflag !== 1'b0) begin
      complete_run();
    end
    host.cmd(8'h2E);
    repeat (2) @(posedge clk_sys);
    chk(32'({sflag, oflag}), 32'h0);
    note("flags");
    v1 = $urandom;
    v2 = $urandom;
    v3 = $urandom;
    host.reg_wr(8'h80, v1);
    rchk(8'hD0, v1);
    host.cmd(8'h50);
    chk(32'({run, full}), 32'h2);
    host.reg_wr(8'h80, v2);
    rchk(8'hD0, v1);
    rchk(8'hC0, v2);
    host.cmd(8'h51);
    chk(32'({run, full}), 32'h3);
    host.reg_wr(8'h80, v3);
    rchk(8'hC0, v2);
    pulse(3'b100);
    chk(32'({run, full}), 32'h2);
    rchk(8'hD0, v2);
    host.reg_wr(8'h90, v3);
    rchk(8'hD0, v3);
    host.reg_wr(8'h80, v1);
    host.cmd(8'h52);
    chk(32'(full), 32'h1);
    host.cmd(8'h26);
    chk(32'(full), 32'h0);
    host.reg_wr(8'h80, v2);
    rchk(8'hC0, v2);
    host.cmd(8'h53);
    chk(32'(full), 32'h1);
    host.cmd(8'h28);
    chk(32'(ovr), 32'h1);
    @(posedge clk_sys);
    chk(32'(ovr), 32'h0);
    host.cmd(8'h49);
    note("queue");
    host.cmd(8'h24);
    host.cmd(8'h04);
    chk(32'({dev, gout, goe, run}), 32'h0);
    rchk(8'hDD, 32'h0);
    rchk(8'hC0, 32'h0);
    note("soft reset");
    complete_run();
  end
endmodule
bind acu_axis_cmd acu_props #(.DATA_W(DATA_W)) i_acu_props (
  .clk_sys(clk_sys), .reset_n(reset_n), .addr(addr), .wr_data(wr_data),
  .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data),
  .gp_pin_out(gp_pin_out), .gp_pin_oe(gp_pin_oe),
  .deviation_clear_pin(deviation_clear_pin),
  .override_two_start(override_two_start),
  .queue_full_flag(queue_full_flag), .stop_irq_flag(stop_irq_flag));
`default_nettype wire
